// ===== sample_rate_generator.sv
// sample rate generator: divided clock, generated frame sync and axi4-lite registers
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
module sample_rate_generator
    import srg_pkg::*;
(
    input  wire logic              I_SYS_CLK,        // 40 MHz system clock
    input  wire logic              I_RESETN,         // synchronous reset, active low
    input  wire logic [ADDR_W-1:0] I_AWADDR,         // write address
    input  wire logic              I_AWVALID,
    output logic                   O_AWREADY,
    input  wire logic [DATA_W-1:0] I_WDATA,          // write data
    input  wire logic [3:0]        I_WSTRB,
    input  wire logic              I_WVALID,
    output logic                   O_WREADY,
    output logic [1:0]             O_BRESP,
    output logic                   O_BVALID,
    input  wire logic              I_BREADY,
    input  wire logic [ADDR_W-1:0] I_ARADDR,         // read address
    input  wire logic              I_ARVALID,
    output logic                   O_ARREADY,
    output logic [DATA_W-1:0]      O_RDATA,
    output logic [1:0]             O_RRESP,
    output logic                   O_RVALID,
    input  wire logic              I_RREADY,
    input  wire logic              I_LOW_SPEED_PERIPHERAL_CLOCK, // internal slow clock
    input  wire logic              I_RECEIVE_CLOCK_PIN,
    input  wire logic              I_TRANSMIT_CLOCK_PIN,
    input  wire logic              I_RECEIVE_FRAME_SYNC_PIN,
    input  wire logic              I_TX_ACTIVITY_FSYNC,          // transmitter-made sync
    output logic                   O_DIVIDED_CLOCK,              // divided clock level
    output logic                   O_DIVIDED_CLOCK_TICK,         // one pulse per period
    output logic                   O_GENERATED_FRAME_SYNC,
    output logic                   O_TX_FRAME_SYNC               // chosen transmit sync
);
    // ****************************************
    // declarations
    // ****************************************
    logic [15:0]       divw_r;                        // divider and pulse width register
    logic [15:0]       pers_r;                        // period and clock source register
    logic              ext_r;                         // clock_mode_extension
    logic [PIN_W-1:0]  pins_s;                        // synchronised pins
    logic              in_lvl, in_prev_r, in_edge;    // selected input clock
    logic              fs_prev_r, fs_edge;            // receive frame sync edge
    src_sel_t          src_sel;
    logic              resync_act;                    // resync mode in force
    logic [7:0]        div_val, width_val;
    logic [11:0]       period_val;
    logic [7:0]        div_cnt_r, div_cnt_nxt;        // input edges in this period
    logic [11:0]       per_cnt_r, per_cnt_nxt;        // divided cycles in this frame
    logic [8:0]        half_val;                      // high phase length
    logic              aw_have_r, w_have_r;           // address and data latched
    logic [ADDR_W-1:0] awaddr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [3:0]        wstrb_r;
    logic              wr_go;                         // both halves present
    logic [DATA_W-1:0] rd_val;
    logic              rd_ok;

    // ****************************************
    // field extraction and source selection
    // ****************************************
    assign div_val    = divw_r[DIV_LSB +: 8];
    assign width_val  = divw_r[WIDTH_LSB +: 8];
    assign period_val = pers_r[PER_MSB:PER_LSB];
    assign src_sel    = src_sel_t'({ext_r, pers_r[CSM_BIT]});
    // resync only with receive clock pin
    assign resync_act = pers_r[RSYNC_BIT] && (src_sel == SRC_RCVPIN);

    // pins pass two flip-flops before use
    pin_sync u_sync (
        .i_clk   (I_SYS_CLK),
        .i_rst_n (I_RESETN),
        .i_async ({I_RECEIVE_FRAME_SYNC_PIN, I_TRANSMIT_CLOCK_PIN,
                   I_RECEIVE_CLOCK_PIN, I_LOW_SPEED_PERIPHERAL_CLOCK}),
        .o_sync  (pins_s)
    );

    // selected level, reserved source gives a still input
    always_comb begin
        case (src_sel)
            SRC_SLOWCLK: in_lvl = pins_s[PIN_LSP];
            SRC_RCVPIN: in_lvl = pins_s[PIN_RCK];
            SRC_XMTPIN: in_lvl = pins_s[PIN_TCK];
            default:    in_lvl = 1'b0;
        endcase
    end

    // previous levels for edge detection
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            in_prev_r <= 1'b0;
            fs_prev_r <= 1'b0;
        end else begin
            in_prev_r <= in_lvl;
            fs_prev_r <= pins_s[PIN_RFS];
        end
    end
    assign in_edge = in_lvl && !in_prev_r;
    assign fs_edge = pins_s[PIN_RFS] && !fs_prev_r;

    // ****************************************
    // clock divider
    // ****************************************
    // next divider count, wraps after divide+1 edges
    always_comb begin
        div_cnt_nxt = div_cnt_r;
        if (resync_act && fs_edge) begin
            div_cnt_nxt = 8'h00;
        end else if (in_edge) begin
            div_cnt_nxt = (div_cnt_r >= div_val) ? 8'h00 : div_cnt_r + 8'h01;
        end
    end
    assign half_val = 9'(({1'b0, div_val} + 9'h001) >> 1);

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            div_cnt_r            <= 8'h00;
            O_DIVIDED_CLOCK_TICK <= 1'b0;
            O_DIVIDED_CLOCK      <= 1'b0;
        end else begin
            div_cnt_r            <= div_cnt_nxt;
            O_DIVIDED_CLOCK_TICK <= in_edge && (div_cnt_r >= div_val) && !(resync_act && fs_edge);
            // divide by one follows the input itself
            if (div_val == 8'h00) begin
                O_DIVIDED_CLOCK <= in_lvl;
            end else begin
                O_DIVIDED_CLOCK <= {1'b0, div_cnt_nxt} < half_val;
            end
        end
    end

    // ****************************************
    // frame sync generation
    // ****************************************
    // next period count per divided cycle
    always_comb begin
        per_cnt_nxt = per_cnt_r;
        if (resync_act && fs_edge) begin
            per_cnt_nxt = 12'h000;
        end else if (O_DIVIDED_CLOCK_TICK) begin
            // free run wraps, resync waits at end
            if (per_cnt_r >= period_val) begin
                per_cnt_nxt = resync_act ? per_cnt_r : 12'h000;
            end else begin
                per_cnt_nxt = per_cnt_r + 12'h001;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            per_cnt_r              <= 12'h000;
            O_GENERATED_FRAME_SYNC <= 1'b0;
        end else begin
            per_cnt_r <= per_cnt_nxt;
            if ((resync_act && fs_edge) || O_DIVIDED_CLOCK_TICK) begin
                // high from count zero for width+1
                O_GENERATED_FRAME_SYNC <= (per_cnt_nxt <= {4'h0, width_val}) &&
                                          !(resync_act && !fs_edge && per_cnt_nxt == per_cnt_r);
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            O_TX_FRAME_SYNC <= 1'b0;
        end else begin
            O_TX_FRAME_SYNC <= pers_r[TXSRC_BIT] ? O_GENERATED_FRAME_SYNC : I_TX_ACTIVITY_FSYNC;
        end
    end

    // ****************************************
    // axi4-lite write channel
    // ****************************************
    assign wr_go = aw_have_r && w_have_r && !O_BVALID;

    // address and data taken in either order
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            O_AWREADY <= 1'b0;
            O_WREADY  <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            wstrb_r   <= 4'h0;
        end else begin
            O_AWREADY <= I_AWVALID && !O_AWREADY && !aw_have_r;
            O_WREADY  <= I_WVALID && !O_WREADY && !w_have_r;
            if (I_AWVALID && O_AWREADY) begin
                aw_have_r <= 1'b1;
                awaddr_r  <= I_AWADDR;
            end else if (wr_go) begin
                aw_have_r <= 1'b0;
            end
            if (I_WVALID && O_WREADY) begin
                w_have_r <= 1'b1;
                wdata_r  <= I_WDATA;
                wstrb_r  <= I_WSTRB;
            end else if (wr_go) begin
                w_have_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            divw_r <= DIVW_RST;
            pers_r <= PERS_RST;
            ext_r  <= CTRL_RST;
        end else if (wr_go) begin
            for (int b = 0; b < 2; b++) begin
                if (wstrb_r[b] && awaddr_r == DIVW_OFS) divw_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
                if (wstrb_r[b] && awaddr_r == PERS_OFS) pers_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
            end
            if (wstrb_r[0] && awaddr_r == CTRL_OFS) ext_r <= wdata_r[0];
        end
    end

    // write response
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            O_BVALID <= 1'b0;
            O_BRESP  <= RESP_OKAY;
        end else if (wr_go) begin
            O_BVALID <= 1'b1;
            O_BRESP  <= ((awaddr_r & MAP_MASK) == 8'h00) ? RESP_OKAY : RESP_SLVERR;
        end else if (I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    // ****************************************
    // axi4-lite read channel
    // ****************************************
    // read mux, status shows live generator state
    always_comb begin
        rd_val = '0;
        rd_ok  = 1'b1;
        case (I_ARADDR)
            DIVW_OFS: rd_val = {16'h0000, divw_r};
            PERS_OFS: rd_val = {16'h0000, pers_r};
            CTRL_OFS: rd_val = {31'h00000000, ext_r};
            STAT_OFS: rd_val = {14'h0000, O_GENERATED_FRAME_SYNC, O_DIVIDED_CLOCK, 4'h0, per_cnt_r};
            default:  rd_ok  = 1'b0;
        endcase
    end

    // address handshake then data
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b0;
            O_RDATA   <= '0;
            O_RRESP   <= RESP_OKAY;
        end else begin
            O_ARREADY <= I_ARVALID && !O_ARREADY && !O_RVALID;
            if (I_ARVALID && O_ARREADY) begin
                O_RVALID <= 1'b1;
                O_RDATA  <= rd_val;
                O_RRESP  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    pulse_width_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (O_DIVIDED_CLOCK_TICK && !resync_act && per_cnt_nxt == {4'h0, width_val} + 12'h001
         && width_val < 8'hff && !$changed(divw_r)) |=> !O_GENERATED_FRAME_SYNC)
        else $error("frame sync longer than width");
    divide_tick_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (in_edge && div_cnt_r == div_val && !resync_act) |=> O_DIVIDED_CLOCK_TICK ##1 !O_DIVIDED_CLOCK_TICK)
        else $error("divided tick missing at wrap");
    src_reserved_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (src_sel == SRC_RESERVED) |=> ($stable(div_cnt_r) && !O_DIVIDED_CLOCK_TICK))
        else $error("divider moved with reserved source");
    period_wrap_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (O_DIVIDED_CLOCK_TICK && per_cnt_r == period_val && !resync_act) |=> per_cnt_r == 12'h000)
        else $error("period count failed to wrap");
    reset_value_a: assert property (@(posedge I_SYS_CLK)
        !I_RESETN |=> (divw_r == DIVW_RST && pers_r == PERS_RST && ext_r == CTRL_RST))
        else $error("wrong register reset value");
    free_run_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (!resync_act && !O_DIVIDED_CLOCK_TICK) |=> per_cnt_r == $past(per_cnt_r))
        else $error("period count moved without tick");
    resync_restart_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (resync_act && fs_edge) |=> (div_cnt_r == 8'h00 && per_cnt_r == 12'h000 && O_GENERATED_FRAME_SYNC))
        else $error("resync did not restart generator");
    tx_source_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        ##1 O_TX_FRAME_SYNC == ($past(pers_r[TXSRC_BIT]) ? $past(O_GENERATED_FRAME_SYNC) : $past(I_TX_ACTIVITY_FSYNC)))
        else $error("wrong transmit frame sync source");
    pulse_start_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (O_DIVIDED_CLOCK_TICK && per_cnt_nxt == 12'h000 && !resync_act) |=> O_GENERATED_FRAME_SYNC)
        else $error("frame sync not high at count zero");
    bvalid_hold_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (O_BVALID && !I_BREADY) |=> O_BVALID)
        else $error("write response dropped early");
endmodule

// ===== srg_pkg.sv
// constants and types shared by the sample rate generator files
package srg_pkg;
    // ****************************************
    // bus geometry
    // ****************************************
    localparam int ADDR_W = 8;                         // register bus address width
    localparam int DATA_W = 32;                        // register bus data width
    localparam int PIN_W  = 4;                         // number of synchronised pins

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] DIVW_OFS = 8'h00;    // clock_divider_and_pulse_width
    localparam logic [ADDR_W-1:0] PERS_OFS = 8'h04;    // frame_period_and_clock_source
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h08;    // clock mode extension control
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h0c;    // generator status, read only
    localparam logic [ADDR_W-1:0] MAP_MASK = 8'hf3;    // bits that must match an offset

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] DIVW_RST = 16'h0001;       // divide value 1, width 0
    localparam logic [15:0] PERS_RST = 16'h2000;       // source mode 1, all else 0
    localparam logic        CTRL_RST = 1'b0;           // extension bit clear

    // ****************************************
    // field positions
    // ****************************************
    localparam int DIV_LSB   = 0;                      // clock_divide_value 7-0
    localparam int WIDTH_LSB = 8;                      // fsync_pulse_width 15-8
    localparam int PER_LSB   = 0;                      // fsync_period 11-0
    localparam int PER_MSB   = 11;
    localparam int TXSRC_BIT = 12;                     // tx_fsync_source_select
    localparam int CSM_BIT   = 13;                     // clock_source_mode
    localparam int RSYNC_BIT = 15;                     // clock_resync_enable

    // ****************************************
    // pin vector slots and bus answers
    // ****************************************
    localparam int PIN_LSP = 0;                        // low_speed_peripheral_clock
    localparam int PIN_RCK = 1;                        // receive_clock_pin
    localparam int PIN_TCK = 2;                        // transmit_clock_pin
    localparam int PIN_RFS = 3;                        // receive_frame_sync_pin
    localparam logic [1:0] RESP_OKAY   = 2'h0;         // access done
    localparam logic [1:0] RESP_SLVERR = 2'h2;         // unmapped offset

    // input clock choice from extension and source mode bits
    typedef enum logic [1:0] {
        SRC_RESERVED,
        SRC_SLOWCLK,
        SRC_RCVPIN,
        SRC_XMTPIN
    } src_sel_t;
endpackage

// ===== pin_sync.sv
// two flip-flop synchroniser for the generator's pin inputs
module pin_sync
    import srg_pkg::*;
(
    input  wire logic             i_clk,    // system clock
    input  wire logic             i_rst_n,  // synchronous reset, active low
    input  wire logic [PIN_W-1:0] i_async,  // raw pin levels
    output logic      [PIN_W-1:0] o_sync    // synchronised levels
);
    logic [PIN_W-1:0] meta_r;               // first stage, read only by second

    // ****************************************
    // one synchroniser per pin
    // ****************************************
    for (genvar g = 0; g < PIN_W; g++) begin : g_bit
        // two stages in series
        always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
                meta_r[g] <= 1'b0;
                o_sync[g] <= 1'b0;
            end else begin
                meta_r[g] <= i_async[g];
                o_sync[g] <= meta_r[g];
            end
        end
    end
endmodule

// ===== serial_clock_partner.sv
// model of the serial port pins and transmitter that feed the sample rate generator
module serial_clock_partner (
    input  wire logic i_clk,   // system clock
    output logic      o_lsp,   // low speed peripheral clock
    output logic      o_rck,   // receive clock pin
    output logic      o_tck,   // transmit clock pin
    output logic      o_rfs,   // receive frame sync pin
    output logic      o_tx_act // transmitter activity frame sync
);
    timeunit 1ns;
    timeprecision 100ps;

    int cnt = 0;               // free cycle count behind the pin clocks

    // pin clocks run free; each level stands at least two system cycles so the synchroniser sees it
    always @(posedge i_clk) begin
        cnt <= cnt + 1;
    end
    assign o_lsp = (cnt % 4) < 2;   // period 4 cycles
    assign o_rck = (cnt % 6) < 3;   // period 6 cycles
    assign o_tck = (cnt % 10) < 5;  // period 10 cycles

    initial begin
        o_rfs = 1'b0;
        o_tx_act = 1'b0;
    end

    // frame sync pin level, changed just after an edge
    task automatic set_fs(input logic v);
        @(posedge i_clk);
        o_rfs <= v;
    endtask

    // transmitter activity level, same clock domain as the generator
    task automatic set_tx(input logic v);
        @(posedge i_clk);
        o_tx_act <= v;
    endtask
endmodule

// ===== sample_rate_generator_tb_top.sv
// self-checking testbench of the sample rate generator
module sample_rate_generator_tb_top;
    import srg_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // signals
    // ****************************************
    logic              clk = 1'b0;     // 40 MHz system clock
    logic              rst_n = 1'b0;   // active low reset
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [3:0]        wstrb = 4'h0;
    logic              awvalid = 1'b0;
    logic              wvalid = 1'b0;
    logic              bready = 1'b0;
    logic              arvalid = 1'b0;
    logic              rready = 1'b0;
    wire               aw_rdy, w_rdy, bvalid, ar_rdy, rvalid;
    wire [1:0]         bresp, rresp;
    wire [DATA_W-1:0]  rdata;
    wire               lsp, rck, tck, rfs, tx_act, dclk, tick, gen_fs, txfs;
    int                fail_count = 0; // mismatches seen
    int                checks = 0;     // comparisons made
    int                cyc = 0;        // cycle count for timing and timeout
    int                t0;             // start of a measured interval
    logic              hit;            // a wait found its level
    logic              prev;           // generated sync one cycle back

    sample_rate_generator dut (
        .I_SYS_CLK(clk), .I_RESETN(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(aw_rdy),
        .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(w_rdy), .O_BRESP(bresp),
        .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(ar_rdy),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
        .I_LOW_SPEED_PERIPHERAL_CLOCK(lsp), .I_RECEIVE_CLOCK_PIN(rck), .I_TRANSMIT_CLOCK_PIN(tck),
        .I_RECEIVE_FRAME_SYNC_PIN(rfs), .I_TX_ACTIVITY_FSYNC(tx_act), .O_DIVIDED_CLOCK(dclk),
        .O_DIVIDED_CLOCK_TICK(tick), .O_GENERATED_FRAME_SYNC(gen_fs), .O_TX_FRAME_SYNC(txfs));

    serial_clock_partner partner (
        .i_clk(clk), .o_lsp(lsp), .o_rck(rck), .o_tck(tck), .o_rfs(rfs), .o_tx_act(tx_act));

    // ****************************************
    // clock and timeout
    // ****************************************
    initial begin
        forever #12.5 clk = ~clk;
    end
    // the longest scenario needs about 16400 cycles; a hang is cut short well after that
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            conclude();
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic conclude();
        if (fail_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // compares one value and counts it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // bus write: address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // waits for the answer; only the bench timeout cuts a hang
        do begin
            @(posedge clk);
            if (awvalid && aw_rdy) awvalid <= 1'b0;
            if (wvalid && w_rdy) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        check(bresp, er);
        bready <= 1'b0;
        @(posedge clk);
    endtask

    // bus read: data and response taken at the edge where rvalid is seen
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = RESP_OKAY,
                          input logic [31:0] m = 32'hffff_ffff);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        // waits for the answer; only the bench timeout cuts a hang
        do begin
            @(posedge clk);
            if (arvalid && ar_rdy) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        check(rdata & m, ed);
        check(rresp, er);
        rready <= 1'b0;
        @(posedge clk);
    endtask

    // waits for the tick (w 0), the generated sync (w 1) or the divided clock (w 2) to show a level
    task automatic wait_lvl(input int w, input logic lvl, input int lim, output logic found);
        int n;
        n = 0;
        found = 1'b0;
        while (!found && n < lim) begin
            @(posedge clk);
            n++;
            found = ((w == 0 ? tick : (w == 1 ? gen_fs : dclk)) === lvl);
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // reset values, every divider and period field writable, upper half and unmapped places
    task automatic regs_scn();
        axi_rd(DIVW_OFS, 32'h0000_0001);
        axi_rd(PERS_OFS, 32'h0000_2000);
        axi_rd(CTRL_OFS, 32'h0000_0000);
        axi_wr(DIVW_OFS, 32'hffff_ffff);
        axi_rd(DIVW_OFS, 32'h0000_ffff);
        axi_wr(PERS_OFS, 32'hffff_ffff);
        axi_rd(PERS_OFS, 32'h0000_ffff);
        axi_wr(8'h10, 32'h0000_1234, RESP_SLVERR);
        axi_rd(8'h10, 32'h0000_0000, RESP_SLVERR);
    endtask

    // divided clock from each input source, and none from the reserved choice
    task automatic div_scn();
        logic [31:0] ext [3] = '{32'h0, 32'h1, 32'h1};
        logic [31:0] mode [3] = '{32'h2000, 32'h0, 32'h2000};
        int per [3] = '{4, 6, 10};
        axi_wr(DIVW_OFS, 32'h0000_0002);
        for (int i = 0; i < 3; i++) begin
            axi_wr(CTRL_OFS, ext[i]);
            axi_wr(PERS_OFS, mode[i]);
            wait_lvl(0, 1'b1, 100, hit);
            wait_lvl(0, 1'b1, 100, hit);
            t0 = cyc;
            wait_lvl(0, 1'b1, 100, hit);
            check(cyc - t0, 3 * per[i]);
            // divided clock level repeats once per divided period
            wait_lvl(2, 1'b0, 100, hit);
            wait_lvl(2, 1'b1, 100, hit);
            t0 = cyc;
            wait_lvl(2, 1'b0, 100, hit);
            wait_lvl(2, 1'b1, 100, hit);
            check(cyc - t0, 3 * per[i]);
        end
        axi_wr(CTRL_OFS, 32'h0);
        axi_wr(PERS_OFS, 32'h0);
        repeat (10) @(posedge clk);
        wait_lvl(0, 1'b1, 100, hit);
        check(hit, 1'b0);
    endtask

    // free-running sync pulse width and spacing, measured in system cycles
    task automatic sync_scn(input logic [31:0] divw, input logic [31:0] pers, input int w, input int p);
        axi_wr(CTRL_OFS, 32'h0);
        axi_wr(DIVW_OFS, divw);
        axi_wr(PERS_OFS, pers);
        wait_lvl(1, 1'b1, p + 200, hit);
        wait_lvl(1, 1'b0, p + 200, hit);
        wait_lvl(1, 1'b1, p + 200, hit);
        t0 = cyc;
        wait_lvl(1, 1'b0, p + 200, hit);
        check(cyc - t0, w);
        wait_lvl(1, 1'b1, p + 200, hit);
        check(cyc - t0, p);
    endtask

    // resync on the receive frame sync pin with the receive clock as input
    task automatic resync_scn();
        axi_wr(DIVW_OFS, 32'h0);
        axi_wr(CTRL_OFS, 32'h1);
        axi_wr(PERS_OFS, 32'h8003);
        repeat (100) @(posedge clk);
        check(gen_fs, 1'b0);
        partner.set_fs(1'b1);
        wait_lvl(1, 1'b1, 8, hit);
        check(hit, 1'b1);
        partner.set_fs(1'b0);
        wait_lvl(1, 1'b0, 40, hit);
        wait_lvl(1, 1'b1, 200, hit);
        check(hit, 1'b0);
        // period count parked at the period value, sync low
        axi_rd(STAT_OFS, 32'h0000_0003, RESP_OKAY, 32'h0002_0fff);
    endtask

    // transmit sync from transmitter activity, then from the generated sync
    task automatic txsel_scn();
        axi_wr(CTRL_OFS, 32'h0);
        axi_wr(PERS_OFS, 32'h2003);
        partner.set_tx(1'b1);
        repeat (3) @(posedge clk);
        check(txfs, 1'b1);
        partner.set_tx(1'b0);
        repeat (3) @(posedge clk);
        check(txfs, 1'b0);
        partner.set_tx(1'b1);
        axi_wr(PERS_OFS, 32'h3003);
        repeat (3) @(posedge clk);
        prev = gen_fs;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            check(txfs, prev);
            prev = gen_fs;
        end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        regs_scn();
        div_scn();
        sync_scn(32'h0000_0100, 32'h0000_2004, 8, 20);
        sync_scn(32'h0000_0001, 32'h0000_2001, 8, 16);
        sync_scn(32'h0000_ff00, 32'h0000_2800, 1024, 8196);
        resync_scn();
        txsel_scn();
        conclude();
    end
endmodule
